// [core/pfc_pkg.sv]
// Constants and types for the interrupt and supply fault controller.
// Assumes a single 8-bit register space reached over the two-wire serial link.
package pfc_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADR_HEALTH = 8'h02;
  localparam logic [7:0] ADR_SMASK = 8'h03;
  localparam logic [7:0] ADR_EMASK = 8'h04;
  localparam logic [7:0] ADR_SFLAG = 8'h05;
  localparam logic [7:0] ADR_EFLAG = 8'h06;
  localparam logic [7:0] ADR_FMASK = 8'h07;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  // ----------------------------------------
  // Sequencing control fields
  // ----------------------------------------
  localparam int CTL_STANDBY = 7;
  localparam int CTL_SLEEP = 6;
  localparam int CTL_OSC = 3;
  localparam int CTL_LOADED = 1;
  localparam int CTL_RESET = 0;
  localparam logic [7:0] CTL_USED = 8'hcb;
  // ----------------------------------------
  // Event flag fields
  // ----------------------------------------
  localparam int EV_PIN_TWO = 5;
  localparam int EV_PIN_ONE = 4;
  // ----------------------------------------
  // Values after reset and for unmapped reads
  // ----------------------------------------
  localparam logic [7:0] RST_FMASK = 8'hff;
  localparam logic [7:0] RST_SMASK = 8'hff;
  localparam logic [7:0] RST_EMASK = 8'hff;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // ----------------------------------------
  // Serial link
  // ----------------------------------------
  localparam logic [3:0] BITS_LAST = 4'h7;
  typedef enum logic [3:0] {
    LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_REG, LS_REG_ACK,
    LS_WDATA, LS_WDATA_ACK, LS_RDATA, LS_RACK
  } pfc_link_st_type;
endpackage : pfc_pkg

// [core/pfc_irq_fault_ctrl.sv]
// Interrupt, supply health and sequencing control registers behind a serial link.
// Assumes the sequencer supplies status levels and a defaults reload pulse on ref_clk,
// and that the link pins are sampled on link_clk, much faster than the serial clock.
`timescale 1ns/1ns
module pfc_irq_fault_ctrl #(
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic system_reset_out_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_n_o,
  output logic int_n_oe,
  input wire logic [7:0] supply_status,
  input wire logic [1:0] conv_status,
  input wire logic [3:0] misc_status,
  input wire logic general_pin_one,
  input wire logic general_pin_two,
  input wire logic [1:0] pin_is_input,
  input wire logic defaults_reload,
  output logic buck_standby_request,
  output logic sleep_request,
  output logic soft_reset_request,
  output logic backlight_osc_select,
  output logic supply_fault_event
);
  if (DEV_ADDR == 7'h00) begin : g_chk
    $error("Device address zero is the general call address");
  end

  // ----------------------------------------
  // State of both domains
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] ctrl, fmask, smask, emask, sflag, eflag, pg_prev, ev_prev;
    logic [2:0] p1_m, p2_m;
    logic [1:0] pin;
    logic [2:0] wr_m;
    logic wr_seen;
    logic [2:0] rd_m;
    logic rd_seen;
    logic rd_ack;
    logic [7:0] rd_data;
    logic pend, int_oe, fault_evt, hold;
  } pfc_ref_type;

  typedef struct packed {
    logic [2:0] rst_m, scl_m, sda_m;
    logic scl, sda, scl_p, sda_p;
    pfc_pkg::pfc_link_st_type st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw, mack;
    logic [7:0] ptr;
    logic [7:0] wr_adr, wr_dat;
    logic wr_tgl;
    logic [7:0] rd_adr;
    logic rd_tgl;
    logic [2:0] ack_m;
    logic ack_seen;
    logic [7:0] rdat;
    logic oe;
  } pfc_link_type;

  pfc_ref_type r_q, r_d;
  pfc_link_type l_q, l_d;

  logic wr_now, rd_now, capture, release_int;
  logic [7:0] ev_now, ev_tog, pg_tog, s_cause, e_cause, wbyte;
  logic hit_ctrl, hit_sflag, hit_eflag;

  // ----------------------------------------
  // Reference clock domain
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    wr_now = 1'b0;
    rd_now = 1'b0;
    r_d.p1_m = {r_q.p1_m[1:0], general_pin_one};
    r_d.p2_m = {r_q.p2_m[1:0], general_pin_two};
    if (r_q.p1_m[1] == r_q.p1_m[2]) begin
      r_d.pin[0] = r_q.p1_m[2];
    end
    if (r_q.p2_m[1] == r_q.p2_m[2]) begin
      r_d.pin[1] = r_q.p2_m[2];
    end
    r_d.wr_m = {r_q.wr_m[1:0], l_q.wr_tgl};
    r_d.rd_m = {r_q.rd_m[1:0], l_q.rd_tgl};
    if (r_q.wr_m[1] == r_q.wr_m[2]) begin
      r_d.wr_seen = r_q.wr_m[2];
      wr_now = r_q.wr_m[2] != r_q.wr_seen;
    end
    if (r_q.rd_m[1] == r_q.rd_m[2]) begin
      r_d.rd_seen = r_q.rd_m[2];
      rd_now = r_q.rd_m[2] != r_q.rd_seen;
    end
    wbyte = l_q.wr_dat;
    hit_ctrl = wr_now && l_q.wr_adr == pfc_pkg::ADR_CTRL;
    hit_sflag = wr_now && l_q.wr_adr == pfc_pkg::ADR_SFLAG;
    hit_eflag = wr_now && l_q.wr_adr == pfc_pkg::ADR_EFLAG;
    // Toggle detection; pin edges only count when the pin is an input
    ev_now = {conv_status, r_q.pin, misc_status};
    ev_tog = ev_now ^ r_q.ev_prev;
    ev_tog[pfc_pkg::EV_PIN_TWO] = ev_tog[pfc_pkg::EV_PIN_TWO] & pin_is_input[1];
    ev_tog[pfc_pkg::EV_PIN_ONE] = ev_tog[pfc_pkg::EV_PIN_ONE] & pin_is_input[0];
    pg_tog = supply_status ^ r_q.pg_prev;
    r_d.ev_prev = ev_now;
    r_d.pg_prev = supply_status;
    r_d.fault_evt = |(pg_tog & ~r_q.fmask);
    s_cause = pg_tog & ~r_q.smask;
    e_cause = ev_tog & ~r_q.emask;
    // Self-clearing request bits
    r_d.ctrl[pfc_pkg::CTL_SLEEP] = 1'b0;
    r_d.ctrl[pfc_pkg::CTL_RESET] = 1'b0;
    if (wr_now) begin
      unique case (l_q.wr_adr)
        pfc_pkg::ADR_SMASK: r_d.smask = wbyte;
        pfc_pkg::ADR_EMASK: r_d.emask = wbyte;
        pfc_pkg::ADR_FMASK: r_d.fmask = wbyte;
        pfc_pkg::ADR_CTRL: r_d.ctrl = wbyte & pfc_pkg::CTL_USED;
        default: ;
      endcase
    end
    if (defaults_reload) begin
      r_d.ctrl[pfc_pkg::CTL_LOADED] = 1'b0;
    end
    // Writing zero clears a flag, writing one keeps it
    release_int = 1'b0;
    if (hit_sflag) begin
      r_d.sflag = r_q.sflag & wbyte;
      release_int = |(r_q.sflag & ~wbyte);
    end
    if (hit_eflag) begin
      r_d.eflag = r_q.eflag & wbyte;
      release_int = |(r_q.eflag & ~wbyte);
    end
    if (r_q.pend && release_int) begin
      r_d.pend = 1'b0;
    end
    // Capture only while idle and out of system reset
    capture = !r_q.pend && system_reset_out_n && |{s_cause, e_cause};
    if (capture) begin
      r_d.sflag = s_cause;
      r_d.eflag = e_cause;
      r_d.pend = 1'b1;
    end
    if (!system_reset_out_n) begin
      r_d.pend = 1'b0;
    end
    r_d.int_oe = r_q.pend && system_reset_out_n;
    r_d.hold = !system_reset_out_n;
    if (rd_now) begin
      r_d.rd_ack = !r_q.rd_ack;
      unique case (l_q.rd_adr)
        pfc_pkg::ADR_HEALTH: r_d.rd_data = supply_status;
        pfc_pkg::ADR_SMASK: r_d.rd_data = r_q.smask;
        pfc_pkg::ADR_EMASK: r_d.rd_data = r_q.emask;
        pfc_pkg::ADR_SFLAG: r_d.rd_data = r_q.sflag;
        pfc_pkg::ADR_EFLAG: r_d.rd_data = r_q.eflag;
        pfc_pkg::ADR_FMASK: r_d.rd_data = r_q.fmask;
        pfc_pkg::ADR_CTRL: r_d.rd_data = r_q.ctrl;
        default: r_d.rd_data = pfc_pkg::RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r_q <= '0;
      r_q.ctrl <= pfc_pkg::RST_CTRL;
      r_q.fmask <= pfc_pkg::RST_FMASK;
      r_q.smask <= pfc_pkg::RST_SMASK;
      r_q.emask <= pfc_pkg::RST_EMASK;
      r_q.sflag <= pfc_pkg::RST_FLAGS;
      r_q.eflag <= pfc_pkg::RST_FLAGS;
      r_q.hold <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign int_n_oe = r_q.int_oe;
  assign int_n_o = r_q.hold & 1'b0;
  assign buck_standby_request = r_q.ctrl[pfc_pkg::CTL_STANDBY];
  assign sleep_request = r_q.ctrl[pfc_pkg::CTL_SLEEP];
  assign soft_reset_request = r_q.ctrl[pfc_pkg::CTL_RESET];
  assign backlight_osc_select = r_q.ctrl[pfc_pkg::CTL_OSC];
  assign supply_fault_event = r_q.fault_evt;

  // ----------------------------------------
  // Link clock domain: serial slave
  // ----------------------------------------
  logic lrst, scl_r, scl_f, l_start, l_stop, ack_now;
  logic [7:0] byte_in;

  always_comb begin
    l_d = l_q;
    ack_now = 1'b0;
    l_d.rst_m = {l_q.rst_m[1:0], r_q.hold};
    lrst = l_q.rst_m[1] | l_q.rst_m[2];
    l_d.scl_m = {l_q.scl_m[1:0], scl_i};
    l_d.sda_m = {l_q.sda_m[1:0], sda_i};
    if (l_q.scl_m[1] == l_q.scl_m[2]) begin
      l_d.scl = l_q.scl_m[2];
    end
    if (l_q.sda_m[1] == l_q.sda_m[2]) begin
      l_d.sda = l_q.sda_m[2];
    end
    l_d.scl_p = l_q.scl;
    l_d.sda_p = l_q.sda;
    l_d.ack_m = {l_q.ack_m[1:0], r_q.rd_ack};
    if (l_q.ack_m[1] == l_q.ack_m[2]) begin
      l_d.ack_seen = l_q.ack_m[2];
      ack_now = l_q.ack_m[2] != l_q.ack_seen;
    end
    if (ack_now) begin
      l_d.rdat = r_q.rd_data;
    end
    scl_r = l_q.scl && !l_q.scl_p;
    scl_f = !l_q.scl && l_q.scl_p;
    l_start = l_q.scl && l_q.scl_p && l_q.sda_p && !l_q.sda;
    l_stop = l_q.scl && l_q.scl_p && !l_q.sda_p && l_q.sda;
    byte_in = {l_q.sh[6:0], l_q.sda};
    unique case (l_q.st)
      pfc_pkg::LS_ADDR, pfc_pkg::LS_REG, pfc_pkg::LS_WDATA: begin
        if (scl_r) begin
          l_d.sh = byte_in;
          l_d.cnt = l_q.cnt + 4'h1;
          if (l_q.cnt == pfc_pkg::BITS_LAST) begin
            l_d.cnt = 4'h0;
            unique case (l_q.st)
              pfc_pkg::LS_ADDR: begin
                l_d.st = pfc_pkg::LS_IDLE;
                if (byte_in[7:1] == DEV_ADDR) begin
                  l_d.st = pfc_pkg::LS_ADDR_ACK;
                  l_d.rw = byte_in[0];
                  l_d.rd_adr = l_q.ptr;
                  l_d.rd_tgl = l_q.rd_tgl ^ byte_in[0];
                end
              end
              pfc_pkg::LS_REG: begin
                l_d.ptr = byte_in;
                l_d.st = pfc_pkg::LS_REG_ACK;
              end
              default: begin
                l_d.wr_adr = l_q.ptr;
                l_d.wr_dat = byte_in;
                l_d.wr_tgl = !l_q.wr_tgl;
                l_d.ptr = l_q.ptr + 8'h01;
                l_d.st = pfc_pkg::LS_WDATA_ACK;
              end
            endcase
          end
        end
      end
      pfc_pkg::LS_ADDR_ACK, pfc_pkg::LS_REG_ACK, pfc_pkg::LS_WDATA_ACK: begin
        if (scl_f) begin
          l_d.oe = !l_q.oe;
          if (l_q.oe) begin
            l_d.st = pfc_pkg::LS_WDATA;
            if (l_q.st == pfc_pkg::LS_ADDR_ACK) begin
              l_d.st = pfc_pkg::LS_REG;
              if (l_q.rw) begin
                l_d.st = pfc_pkg::LS_RDATA;
                l_d.sh = l_q.rdat;
                l_d.oe = !l_q.rdat[7];
              end
            end
          end
        end
      end
      pfc_pkg::LS_RDATA: begin
        if (scl_f) begin
          l_d.cnt = l_q.cnt + 4'h1;
          l_d.sh = {l_q.sh[6:0], 1'b0};
          l_d.oe = !l_q.sh[6];
          if (l_q.cnt == pfc_pkg::BITS_LAST) begin
            l_d.oe = 1'b0;
            l_d.cnt = 4'h0;
            l_d.st = pfc_pkg::LS_RACK;
          end
        end
      end
      pfc_pkg::LS_RACK: begin
        if (scl_r) begin
          l_d.mack = !l_q.sda;
          if (!l_q.sda) begin
            l_d.ptr = l_q.ptr + 8'h01;
            l_d.rd_adr = l_q.ptr + 8'h01;
            l_d.rd_tgl = !l_q.rd_tgl;
          end
        end
        if (scl_f) begin
          l_d.st = pfc_pkg::LS_IDLE;
          if (l_q.mack) begin
            l_d.st = pfc_pkg::LS_RDATA;
            l_d.sh = l_q.rdat;
            l_d.oe = !l_q.rdat[7];
          end
        end
      end
      default: ;
    endcase
    // Stop or start override any phase; no timeout exists
    if (l_stop) begin
      l_d.st = pfc_pkg::LS_IDLE;
      l_d.oe = 1'b0;
    end
    if (l_start) begin
      l_d.st = pfc_pkg::LS_ADDR;
      l_d.cnt = 4'h0;
      l_d.oe = 1'b0;
    end
    if (lrst) begin
      l_d = '0;
      l_d.rst_m = {l_q.rst_m[1:0], r_q.hold};
      l_d.scl = 1'b1;
      l_d.sda = 1'b1;
      l_d.scl_p = 1'b1;
      l_d.sda_p = 1'b1;
      // Toggles restart at zero; a stray one reaches only unmapped address zero
      l_d.st = pfc_pkg::LS_IDLE;
    end
  end

  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end

  assign sda_oe = l_q.oe;
  assign sda_o = l_q.rw & 1'b0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  flags_then_int_a: assert property (@(posedge ref_clk) disable iff (srst)
    capture |=> (r_q.sflag != 8'h00 || r_q.eflag != 8'h00) && !int_n_oe ##1 int_n_oe)
    else $error("Interrupt did not follow flag capture");
  flags_frozen_a: assert property (@(posedge ref_clk) disable iff (srst)
    r_q.pend && !hit_sflag && !hit_eflag |=> $stable(r_q.sflag) && $stable(r_q.eflag))
    else $error("Flags changed while interrupt pending");
  no_timeout_a: assert property (@(posedge ref_clk) disable iff (srst)
    r_q.pend && system_reset_out_n && !wr_now |=> r_q.pend)
    else $error("Pending interrupt released without a clear");
  ack_release_a: assert property (@(posedge ref_clk) disable iff (srst)
    r_q.pend && hit_sflag && |(r_q.sflag & ~wbyte) |=> !r_q.pend ##1 !int_n_oe)
    else $error("Clearing a flag did not release the interrupt");
  sleep_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    sleep_request && !hit_ctrl |=> !sleep_request)
    else $error("Sleep bit did not clear itself");
  reset_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    soft_reset_request && !hit_ctrl |=> !soft_reset_request)
    else $error("Reset bit did not clear itself");
  fault_event_a: assert property (@(posedge ref_clk) disable iff (srst)
    |((supply_status ^ r_q.pg_prev) & ~r_q.fmask) |=> supply_fault_event)
    else $error("Unmasked supply change gave no fault event");
  sysrst_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
    !system_reset_out_n |=> !int_n_oe && !r_q.pend)
    else $error("Interrupt driven during system reset");
  mask_reset_a: assert property (@(posedge ref_clk)
    $fell(srst) |-> r_q.fmask == pfc_pkg::RST_FMASK)
    else $error("Fault mask not fully masked after reset");
  loaded_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    defaults_reload |=> !r_q.ctrl[pfc_pkg::CTL_LOADED])
    else $error("Defaults reload did not clear loaded flag");
  one_noop_a: assert property (@(posedge ref_clk) disable iff (srst)
    hit_sflag && wbyte == 8'hff && !capture |=> $stable(r_q.sflag))
    else $error("Writing ones changed the supply flags");
endmodule : pfc_irq_fault_ctrl

// [testbench/pfc_host_model.sv]
// Serial host model: a bus master that reads and writes the controller registers.
// Assumes an open-drain SDA line with pull-up resolved by the bench; SCL is driven directly and idles high.
`timescale 1ns/1ns
module pfc_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h48 // Arbitrary bus address
) (
  output logic scl,
  output logic sda_pull,
  input wire logic sda,
  input wire logic int_n
);
  // ----------------------------------------
  // Bit and byte timing
  // ----------------------------------------
  localparam int HALF = 1000;
  logic nacked;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    nacked = 1'b0;
  end
  task automatic clk_bit(input logic b, output logic s);
    sda_pull = ~b;
    #(HALF / 2);
    scl = 1'b1;
    #(HALF / 2);
    s = sda;
    #(HALF / 2);
    scl = 1'b0;
    #(HALF / 2);
  endtask : clk_bit
  task automatic start();
    sda_pull = 1'b0;
    #(HALF / 2);
    scl = 1'b1;
    #(HALF / 2);
    sda_pull = 1'b1;
    #(HALF / 2);
    scl = 1'b0;
    #(HALF / 2);
  endtask : start
  task automatic stop();
    sda_pull = 1'b1;
    #(HALF / 2);
    scl = 1'b1;
    #(HALF / 2);
    sda_pull = 1'b0;
    #HALF;
  endtask : stop
  task automatic byte_io(input logic [7:0] tx, input logic want_ack, output logic [7:0] rx);
    logic s;
    for (int j = 7; j >= 0; j--) begin
      clk_bit(tx[j], rx[j]);
    end
    clk_bit(1'b1, s);
    if (want_ack && s !== 1'b0) begin
      nacked = 1'b1;
    end
  endtask : byte_io
  // ----------------------------------------
  // Register transfers
  // ----------------------------------------
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] x;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, x);
    byte_io(adr, 1'b1, x);
    byte_io(d, 1'b1, x);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] adr, output logic [7:0] d);
    logic [7:0] x;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, x);
    byte_io(adr, 1'b1, x);
    start();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, x);
    byte_io(8'hff, 1'b0, d);
    stop();
  endtask : rd
  // Host gives up after the address byte and two pointer bits
  task automatic abort();
    logic [7:0] x;
    logic s;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, x);
    clk_bit(1'b0, s);
    clk_bit(1'b1, s);
    stop();
  endtask : abort
endmodule : pfc_host_model

// [testbench/tb.sv]
// Self-checking bench for the interrupt and supply fault controller.
// Assumes pfc_pkg, the design and the serial host model are compiled first.
`timescale 1ns/1ns
module tb;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic system_reset_out_n = 1'b0;
  logic [7:0] supply_status = 8'h00;
  logic [1:0] conv_status = 2'h0;
  logic [3:0] misc_status = 4'h0;
  logic general_pin_one = 1'b0;
  logic general_pin_two = 1'b0;
  logic [1:0] pin_is_input = 2'h0;
  logic defaults_reload = 1'b0;
  logic sda_oe, int_n_oe, buck_standby_request, sleep_request, soft_reset_request;
  logic backlight_osc_select, supply_fault_event, sda_o, int_n_o;
  wire logic scl;
  wire logic host_pull;
  wire logic sda = ~host_pull & (sda_oe ? sda_o : 1'b1);
  wire logic int_n = int_n_oe ? int_n_o : 1'b1;
  logic [7:0] n_sleep = 8'h00, n_reset = 8'h00, n_fault = 8'h00, v;
  int num_errors = 0, cmp_count = 0, seed, k, m, i;
  logic [7:0] adr_t [7] = '{pfc_pkg::ADR_SMASK, pfc_pkg::ADR_EMASK, pfc_pkg::ADR_FMASK,
    pfc_pkg::ADR_SFLAG, pfc_pkg::ADR_EFLAG, pfc_pkg::ADR_CTRL, 8'h10};
  logic [7:0] val_t [7] = '{pfc_pkg::RST_SMASK, pfc_pkg::RST_EMASK, pfc_pkg::RST_FMASK,
    pfc_pkg::RST_FLAGS, pfc_pkg::RST_FLAGS, pfc_pkg::RST_CTRL, pfc_pkg::RD_UNMAPPED};

  always #25 ref_clk = ~ref_clk;
  initial begin
    #17;
    forever #40 link_clk = ~link_clk;
  end

  pfc_irq_fault_ctrl pfc_irq_fault_ctrl_i (.ref_clk(ref_clk), .srst(srst), .link_clk(link_clk),
    .system_reset_out_n(system_reset_out_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe), .supply_status(supply_status),
    .conv_status(conv_status), .misc_status(misc_status), .general_pin_one(general_pin_one),
    .general_pin_two(general_pin_two), .pin_is_input(pin_is_input),
    .defaults_reload(defaults_reload), .buck_standby_request(buck_standby_request),
    .sleep_request(sleep_request), .soft_reset_request(soft_reset_request),
    .backlight_osc_select(backlight_osc_select), .supply_fault_event(supply_fault_event));
  pfc_host_model pfc_host_model_i (.scl(scl), .sda_pull(host_pull), .sda(sda), .int_n(int_n));

  // Pulse counters for the one-cycle request and fault event outputs
  always @(posedge ref_clk) begin
    if (sleep_request === 1'b1) n_sleep <= n_sleep + 8'h01;
    if (soft_reset_request === 1'b1) n_reset <= n_reset + 8'h01;
    if (supply_fault_event === 1'b1) n_fault <= n_fault + 8'h01;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: level %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] d;
    pfc_host_model_i.rd(adr, d);
    chk_reg(d, exp);
  endtask : rd_chk
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    pfc_host_model_i.wr(adr, d);
  endtask : wr
  // Toggles the source behind event flag bit n
  task automatic ev_flip(input int n);
    if (n >= 6) conv_status[n - 6] = ~conv_status[n - 6];
    else if (n == 5) general_pin_two = ~general_pin_two;
    else if (n == 4) general_pin_one = ~general_pin_one;
    else misc_status[n] = ~misc_status[n];
  endtask : ev_flip
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    #4800000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    seed = 63893;
    supply_status = 8'($random(seed));
    tick(3);
    srst = 1'b0;
    tick(7);
    system_reset_out_n = 1'b1;
    tick(40);
    for (i = 0; i < 7; i++) rd_chk(adr_t[i], val_t[i]);
    $display("Test reset values done");
    for (i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      wr(adr_t[i], v);
      rd_chk(adr_t[i], v);
    end
    wr(pfc_pkg::ADR_HEALTH, ~supply_status);
    rd_chk(pfc_pkg::ADR_HEALTH, supply_status);
    $display("Test register access done");
    wr(pfc_pkg::ADR_CTRL, 8'h88);
    chk_bit(buck_standby_request, 1'b1);
    chk_bit(backlight_osc_select, 1'b1);
    wr(pfc_pkg::ADR_CTRL, 8'h43);
    chk_reg(n_sleep, 8'h01);
    chk_reg(n_reset, 8'h01);
    chk_bit(buck_standby_request, 1'b0);
    chk_bit(backlight_osc_select, 1'b0);
    rd_chk(pfc_pkg::ADR_CTRL, 8'h02);
    defaults_reload = 1'b1;
    tick(1);
    defaults_reload = 1'b0;
    tick(2);
    rd_chk(pfc_pkg::ADR_CTRL, 8'h00);
    $display("Test sequencing control done");
    k = {$random(seed)} % 8;
    m = (k + 3) % 8;
    wr(pfc_pkg::ADR_EMASK, 8'hff);
    wr(pfc_pkg::ADR_FMASK, ~(8'h01 << k));
    wr(pfc_pkg::ADR_SMASK, ~(8'h01 << k));
    v = n_fault;
    supply_status[k] = ~supply_status[k];
    supply_status[m] = ~supply_status[m];
    tick(4);
    chk_reg(n_fault, v + 8'h01);
    chk_bit(int_n, 1'b0);
    rd_chk(pfc_pkg::ADR_SFLAG, 8'h01 << k);
    wr(pfc_pkg::ADR_SMASK, ~((8'h01 << k) | (8'h01 << m)));
    supply_status[k] = ~supply_status[k];
    supply_status[m] = ~supply_status[m];
    tick(4);
    chk_reg(n_fault, v + 8'h02);
    rd_chk(pfc_pkg::ADR_SFLAG, 8'h01 << k);
    pfc_host_model_i.abort();
    tick(40);
    chk_bit(int_n, 1'b0);
    wr(pfc_pkg::ADR_SFLAG, 8'hff);
    chk_bit(int_n, 1'b0);
    rd_chk(pfc_pkg::ADR_SFLAG, 8'h01 << k);
    wr(pfc_pkg::ADR_SFLAG, 8'h00);
    chk_bit(int_n, 1'b1);
    supply_status[m] = ~supply_status[m];
    tick(4);
    chk_bit(int_n, 1'b0);
    rd_chk(pfc_pkg::ADR_SFLAG, 8'h01 << m);
    wr(pfc_pkg::ADR_SFLAG, 8'h00);
    $display("Test supply interrupt done");
    wr(pfc_pkg::ADR_EMASK, 8'h00);
    pin_is_input = 2'h3;
    for (int r = 0; r < 10; r++) begin
      i = (r < 8) ? r : r - 4;
      ev_flip(i);
      tick(30);
      chk_bit(int_n, 1'b0);
      rd_chk(pfc_pkg::ADR_EFLAG, 8'h01 << i);
      wr(pfc_pkg::ADR_EFLAG, 8'h00);
      chk_bit(int_n, 1'b1);
    end
    pin_is_input = 2'h0;
    ev_flip(4);
    tick(30);
    chk_bit(int_n, 1'b1);
    $display("Test event interrupts done");
    system_reset_out_n = 1'b0;
    tick(4);
    supply_status[m] = ~supply_status[m];
    ev_flip(0);
    tick(20);
    chk_bit(int_n_oe, 1'b0);
    system_reset_out_n = 1'b1;
    tick(40);
    wr(pfc_pkg::ADR_SFLAG, 8'h00);
    wr(pfc_pkg::ADR_EFLAG, 8'h00);
    chk_bit(int_n, 1'b1);
    chk_bit(pfc_host_model_i.nacked, 1'b0);
    $display("Test system reset done");
    give_verdict();
  end
endmodule : tb
